// ===== shared/chps_pkg.sv
// Shared constants for the CPU halt power-save controller.
// Assumes one system clock and an active-low asynchronous reset.
package chps_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    // External sources 0-6, 20-25, 30, 31, 100, 101, 110, 111
    localparam int unsigned NUM_EXT = 19;
    localparam int unsigned PRIO_W = 3;
    localparam int unsigned SYNC_W = NUM_EXT + 1;
    // Bit of the synchroniser vector that carries the NMI pin
    localparam int unsigned NMI_BIT = NUM_EXT;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_CPU_CLK_EN = 1'h1;
    localparam logic RST_SYS_ON = 1'h1;
    localparam logic RST_PULSE = 1'h0;
    localparam logic RST_HALTED = 1'h0;
    localparam logic [SYNC_W-1:0] RST_SYNC = 20'h00000;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        CHPS_RUN,
        CHPS_HALT
    } chps_state_t;

endpackage

// ===== shared/chps_wake_if.sv
// Wake-source evaluation signals between the halt controller and its
// wake decision logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface chps_wake_if;
    logic nmi;
    logic [chps_pkg::NUM_EXT-1:0] ext_req;
    logic [chps_pkg::NUM_EXT-1:0] mask;
    logic ei;
    logic isr_active;
    logic [chps_pkg::PRIO_W-1:0] isr_prio;
    logic nmi_busy;
    logic [chps_pkg::PRIO_W-1:0] req_prio;
    logic wake;
    logic mask_live;
    logic ack_nmi;
    logic ack_mask;
    logic branch;
    logic exec_next;
    logic hold_pending;

    modport eval (
        input nmi, ext_req, mask, ei, isr_active, isr_prio, nmi_busy,
        input req_prio,
        output wake, mask_live, ack_nmi, ack_mask, branch, exec_next,
        output hold_pending
    );
    modport ctrl (
        output nmi, ext_req, mask, ei, isr_active, isr_prio, nmi_busy,
        output req_prio,
        input wake, mask_live, ack_nmi, ack_mask, branch, exec_next,
        input hold_pending
    );
endinterface

// ===== rtl/chps_sync.sv
// Two-stage synchroniser for the asynchronous request pins.
// Assumes the pins are level requests held until serviced.
`timescale 1ns/1ns
module chps_sync (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [chps_pkg::SYNC_W-1:0] i_async,
    output logic [chps_pkg::SYNC_W-1:0] o_sync
);
    typedef struct packed {
        logic [chps_pkg::SYNC_W-1:0] meta;
        logic [chps_pkg::SYNC_W-1:0] stable;
    } chps_sync_t;

    chps_sync_t r;
    chps_sync_t next_r;

    always_comb begin
        next_r = r;
        next_r.meta = i_async;
        // First stage feeds only the second
        next_r.stable = r.meta;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r.meta <= chps_pkg::RST_SYNC;
            r.stable <= chps_pkg::RST_SYNC;
        end else begin
            r <= next_r;
        end
    end

    assign o_sync = r.stable;
endmodule // chps_sync

// ===== rtl/chps_wake_eval.sv
// Wake decision: which request ends the halt, and how the CPU resumes.
// Assumes priority codes where a smaller value is more urgent, and
// req_prio is the level of the most urgent unmasked pending request.
`timescale 1ns/1ns
module chps_wake_eval (
    chps_wake_if.eval wk
);
    logic higher;

    always_comb begin
        wk.mask_live = |(wk.ext_req & ~wk.mask);
        // Any live source wakes, whatever its level
        wk.wake = wk.nmi | wk.mask_live;
        higher = !wk.isr_active || (wk.req_prio < wk.isr_prio);
        // NMI ignores the enable state; only a running NMI blocks it
        wk.ack_nmi = wk.nmi && !wk.nmi_busy;
        wk.ack_mask = !wk.nmi && wk.mask_live && wk.ei && higher &&
            !wk.nmi_busy;
        wk.branch = wk.ack_nmi || wk.ack_mask;
        wk.exec_next = wk.wake && !wk.branch;
        // A request that wakes but is not taken stays pending
        wk.hold_pending = (wk.nmi && !wk.ack_nmi) ||
            (wk.mask_live && !wk.ack_mask);
    end
endmodule // chps_wake_eval

// ===== rtl/chps_top.sv
// CPU halt power-save controller: gates the CPU clock on the halt
// instruction and restores it on an interrupt request or reset.
// Assumes the CPU core and interrupt controller share i_clk; the NMI
// and external request pins are asynchronous.
//
// Functional notes
// RULE1 - Only the CPU's halt instruction puts the block into halt.
// RULE2 - In halt only the CPU clock stops; generator and system clock run.
// RULE3 - In halt every on-chip peripheral keeps its clock.
// RULE4 - In halt peripherals free of CPU instructions work on, ports aside.
// RULE5 - Halt preserves CPU registers, RAM and port states as they were.
// RULE6 - Halt ends on NMI, an unmasked external request, or the reset pin.
// RULE7 - Any such request wakes the CPU whatever its priority.
// RULE8 - Halted in a routine, a less urgent request wakes but stays pending.
// RULE9 - Halted in a routine, a more urgent request or NMI is taken.
// RULE10 - An NMI wake always branches to the handler, enabled or not; here it stays pending while an NMI is in service.
// RULE11 - Maskable wake: branch or resume when enabled, resume when disabled.
// RULE12 - Reset-pin wake is the same as an ordinary reset.
// RULE13 - In halt the external bus and the clock output pin keep running.
`timescale 1ns/1ns
module chps_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_halt_exec,
    input wire logic i_nmi_pin,
    input wire logic [chps_pkg::NUM_EXT-1:0] i_ext_irq_input,
    input wire logic [chps_pkg::NUM_EXT-1:0] i_irq_mask,
    input wire logic i_irq_enabled_state,
    input wire logic i_isr_active,
    input wire logic [chps_pkg::PRIO_W-1:0] i_isr_prio,
    input wire logic i_nmi_in_service,
    input wire logic [chps_pkg::PRIO_W-1:0] i_req_prio,
    output logic o_cpu_clk_en,
    output logic o_sys_clk_en,
    output logic o_periph_clk_en,
    output logic o_bus_run,
    output logic o_clock_output_pin_en,
    output logic o_state_hold,
    output logic o_halted,
    output logic o_wake,
    output logic o_ack_nmi,
    output logic o_ack_mask,
    output logic o_branch_handler,
    output logic o_exec_next,
    output logic o_hold_pending
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        chps_pkg::chps_state_t state;
        logic cpu_clk_en;
        logic sys_on;
        logic periph_on;
        logic bus_on;
        logic clock_output_pin_on;
        logic hold;
        logic halted;
        logic wake;
        logic ack_nmi;
        logic ack_mask;
        logic branch;
        logic exec_next;
        logic hold_pending;
    } chps_top_t;

    chps_top_t r;
    chps_top_t next_r;
    logic [chps_pkg::SYNC_W-1:0] pins_async;
    logic [chps_pkg::SYNC_W-1:0] pins_sync;

    chps_wake_if wk ();

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins_async = {i_nmi_pin, i_ext_irq_input};

    chps_sync u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(pins_async),
        .o_sync(pins_sync)
    );

    // ------------------------------------------------------------
    // Wake evaluation
    // ------------------------------------------------------------
    assign wk.nmi = pins_sync[chps_pkg::NMI_BIT];
    assign wk.ext_req = pins_sync[chps_pkg::NUM_EXT-1:0];
    assign wk.mask = i_irq_mask;
    assign wk.ei = i_irq_enabled_state;
    assign wk.isr_active = i_isr_active;
    assign wk.isr_prio = i_isr_prio;
    assign wk.nmi_busy = i_nmi_in_service;
    assign wk.req_prio = i_req_prio;

    chps_wake_eval u_eval (
        .wk(wk)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.wake = chps_pkg::RST_PULSE;
        next_r.ack_nmi = chps_pkg::RST_PULSE;
        next_r.ack_mask = chps_pkg::RST_PULSE;
        next_r.branch = chps_pkg::RST_PULSE;
        next_r.exec_next = chps_pkg::RST_PULSE;
        next_r.hold_pending = chps_pkg::RST_PULSE;
        // Generator, system, peripheral, bus and clock-out never stop
        next_r.sys_on = 1'h1; // RULE2
        next_r.periph_on = 1'h1; // RULE3
        next_r.bus_on = 1'h1; // RULE13
        next_r.clock_output_pin_on = 1'h1; // RULE13
        case (r.state)
            chps_pkg::CHPS_RUN: begin
                // Entry only through the halt instruction
                if (i_halt_exec) begin // RULE1
                    next_r.state = chps_pkg::CHPS_HALT;
                    next_r.cpu_clk_en = 1'h0; // RULE2
                    // Freezes CPU, RAM and port writes
                    next_r.hold = 1'h1; // RULE5
                    next_r.halted = 1'h1;
                end
            end
            chps_pkg::CHPS_HALT: begin
                // Priority does not gate the wake itself
                if (wk.wake) begin // RULE6 RULE7
                    next_r.state = chps_pkg::CHPS_RUN;
                    next_r.cpu_clk_en = 1'h1;
                    next_r.hold = 1'h0;
                    next_r.halted = 1'h0;
                    next_r.wake = 1'h1;
                    next_r.ack_nmi = wk.ack_nmi; // RULE9 RULE10
                    next_r.ack_mask = wk.ack_mask; // RULE9 RULE11
                    next_r.branch = wk.branch; // RULE10 RULE11
                    next_r.exec_next = wk.exec_next; // RULE11
                    next_r.hold_pending = wk.hold_pending; // RULE8
                end
            end
            default: begin
                next_r.state = chps_pkg::CHPS_RUN;
                next_r.cpu_clk_en = 1'h1;
                next_r.hold = 1'h0;
                next_r.halted = 1'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset pin wake takes the same path as any reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin // RULE12
            r.state <= chps_pkg::CHPS_RUN;
            r.cpu_clk_en <= chps_pkg::RST_CPU_CLK_EN;
            r.sys_on <= chps_pkg::RST_SYS_ON;
            r.periph_on <= chps_pkg::RST_SYS_ON;
            r.bus_on <= chps_pkg::RST_SYS_ON;
            r.clock_output_pin_on <= chps_pkg::RST_SYS_ON;
            r.hold <= chps_pkg::RST_HALTED;
            r.halted <= chps_pkg::RST_HALTED;
            r.wake <= chps_pkg::RST_PULSE;
            r.ack_nmi <= chps_pkg::RST_PULSE;
            r.ack_mask <= chps_pkg::RST_PULSE;
            r.branch <= chps_pkg::RST_PULSE;
            r.exec_next <= chps_pkg::RST_PULSE;
            r.hold_pending <= chps_pkg::RST_PULSE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Clock gating cell sits outside; a glitch-free gate is assumed
    assign o_cpu_clk_en = r.cpu_clk_en;
    assign o_sys_clk_en = r.sys_on;
    assign o_periph_clk_en = r.periph_on; // RULE4
    assign o_bus_run = r.bus_on;
    assign o_clock_output_pin_en = r.clock_output_pin_on;
    assign o_state_hold = r.hold;
    assign o_halted = r.halted;
    assign o_wake = r.wake;
    assign o_ack_nmi = r.ack_nmi;
    assign o_ack_mask = r.ack_mask;
    assign o_branch_handler = r.branch;
    assign o_exec_next = r.exec_next;
    assign o_hold_pending = r.hold_pending;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    halt_entry_a: assert property ( // RULE1
        (!o_halted && i_halt_exec) |=> o_halted && !o_cpu_clk_en
    ) else $error("halt instruction did not halt");

    no_self_halt_a: assert property ( // RULE1
        (!o_halted && !i_halt_exec) |=> !o_halted
    ) else $error("halt entered without instruction");

    cpu_gate_a: assert property ( // RULE2
        o_halted |-> !o_cpu_clk_en && o_sys_clk_en
    ) else $error("clock gating wrong in halt");

    periph_clk_a: assert property ( // RULE3
        o_halted |-> o_periph_clk_en
    ) else $error("peripheral clock stopped in halt");

    state_hold_a: assert property ( // RULE5
        o_halted |-> o_state_hold
    ) else $error("state not held in halt");

    wake_exit_a: assert property ( // RULE6
        (o_halted && (wk.nmi || wk.mask_live))
            |=> !o_halted && o_wake && o_cpu_clk_en
    ) else $error("request did not end halt");

    stay_halted_a: assert property ( // RULE6
        (o_halted && !wk.nmi && !wk.mask_live) |=> o_halted && !o_wake
    ) else $error("halt ended without source");

    any_prio_a: assert property ( // RULE7
        (o_halted && wk.mask_live && i_isr_active
            && (i_req_prio >= i_isr_prio)) |=> o_wake
    ) else $error("low priority request did not wake");

    low_pending_a: assert property ( // RULE8
        (o_halted && !wk.nmi && wk.mask_live && i_isr_active
            && (i_req_prio >= i_isr_prio))
            |=> !o_ack_mask && o_hold_pending && o_exec_next
    ) else $error("lower priority request was taken");

    high_taken_a: assert property ( // RULE9
        (o_halted && !wk.nmi && wk.mask_live && i_isr_active
            && i_irq_enabled_state && !i_nmi_in_service
            && (i_req_prio < i_isr_prio))
            |=> o_ack_mask && o_branch_handler
    ) else $error("higher priority request not taken");

    nmi_branch_a: assert property ( // RULE10
        (o_halted && wk.nmi && !i_nmi_in_service)
            |=> o_ack_nmi && o_branch_handler && !o_exec_next
    ) else $error("NMI wake did not branch");

    di_resume_a: assert property ( // RULE11
        (o_halted && !wk.nmi && wk.mask_live && !i_irq_enabled_state)
            |=> o_exec_next && !o_branch_handler
    ) else $error("disabled wake did not resume");

    bus_alive_a: assert property ( // RULE13
        o_halted |-> o_bus_run && o_clock_output_pin_en
    ) else $error("bus or clock output stopped in halt");

    wake_pulse_a: assert property ( // RULE6
        o_wake |=> !o_wake
    ) else $error("wake pulse longer than one cycle");

endmodule // chps_top

// ===== tb/chps_cpu_model.sv
// Partner model: interrupt controller and CPU core facing the block.
// Assumes the bench drives the pins and masks on the rising clock edge.
`timescale 1ns/1ns
module chps_cpu_model (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [chps_pkg::NUM_EXT-1:0] i_ext_irq_input,
    input wire logic [chps_pkg::NUM_EXT-1:0] i_irq_mask,
    input wire logic i_cpu_clk_en,
    output logic [chps_pkg::PRIO_W-1:0] o_req_prio,
    output logic [15:0] o_steps
);
    logic [chps_pkg::PRIO_W-1:0] best;

    // ------------------------------------------------------------
    // Interrupt controller: most urgent unmasked pending level
    // ------------------------------------------------------------
    // Source n sits at level n modulo 8; idle reports the least urgent
    always_comb begin
        best = 3'h7;
        for (int n = 0; n < chps_pkg::NUM_EXT; n++) begin
            if (i_ext_irq_input[n] && !i_irq_mask[n] && 3'(n) < best) begin
                best = 3'(n);
            end
        end
    end

    // ------------------------------------------------------------
    // CPU core: a step counter that only moves on the gated clock
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_req_prio <= 3'h7;
            o_steps <= 16'h0000;
        end else begin
            o_req_prio <= best;
            if (i_cpu_clk_en) begin
                o_steps <= o_steps + 16'h0001;
            end
        end
    end
endmodule // chps_cpu_model

// ===== tb/cpu_halt_power_save_tb.sv
// Self-checking bench for the CPU halt power-save controller.
// Assumes the partner model supplies the pending request level.
`timescale 1ns/1ns
module cpu_halt_power_save_tb;
    logic clk, rstn, halt_exec, nmi_pin, ei, isr_active, nmi_in_service;
    logic [18:0] ext, mask;
    logic [2:0] isr_prio, req_prio;
    logic cpu_clk_en, sys_clk_en, periph_clk_en, bus_run, clock_output_pin_en;
    logic state_hold, halted, o_wake, ack_nmi, ack_mask, branch;
    logic exec_next, hold_pending;
    logic [15:0] steps;
    int num_errors = 0;
    int samples_checked = 0;

    chps_top dut (.i_clk(clk), .i_rstn(rstn), .i_halt_exec(halt_exec),
        .i_nmi_pin(nmi_pin), .i_ext_irq_input(ext), .i_irq_mask(mask),
        .i_irq_enabled_state(ei), .i_isr_active(isr_active),
        .i_isr_prio(isr_prio), .i_nmi_in_service(nmi_in_service),
        .i_req_prio(req_prio), .o_cpu_clk_en(cpu_clk_en),
        .o_sys_clk_en(sys_clk_en), .o_periph_clk_en(periph_clk_en),
        .o_bus_run(bus_run), .o_clock_output_pin_en(clock_output_pin_en),
        .o_state_hold(state_hold), .o_halted(halted), .o_wake(o_wake),
        .o_ack_nmi(ack_nmi), .o_ack_mask(ack_mask),
        .o_branch_handler(branch), .o_exec_next(exec_next),
        .o_hold_pending(hold_pending));

    chps_cpu_model partner (.i_clk(clk), .i_rstn(rstn),
        .i_ext_irq_input(ext), .i_irq_mask(mask),
        .i_cpu_clk_en(cpu_clk_en), .o_req_prio(req_prio), .o_steps(steps));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_bit(input string name, input logic exp,
                           input logic got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %b seen %b", name, exp, got);
            num_errors++;
        end
    endtask

    task automatic chk_vec(input string name, input logic [4:0] exp,
                           input logic [4:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    task automatic test_done;
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------
    // System and peripheral clocks, bus and clock pin must run in either state
    task automatic chk_always_on;
        chk_bit("sys clk", 1'h1, sys_clk_en);
        chk_bit("periph clk", 1'h1, periph_clk_en);
        chk_bit("bus run", 1'h1, bus_run);
        chk_bit("clock pin", 1'h1, clock_output_pin_en);
    endtask

    task automatic chk_idle;
        chk_always_on();
        chk_bit("cpu clk", 1'h1, cpu_clk_en);
        chk_bit("halted", 1'h0, halted);
        chk_bit("state hold", 1'h0, state_hold);
        chk_bit("wake", 1'h0, o_wake);
        chk_vec("decision", 5'h00, {ack_nmi, ack_mask, branch, exec_next,
                                    hold_pending});
    endtask

    task automatic do_halt;
        @(posedge clk);
        halt_exec <= 1'h1;
        @(posedge clk);
        halt_exec <= 1'h0;
        @(negedge clk);
        chk_bit("halted", 1'h1, halted);
        chk_bit("cpu clk", 1'h0, cpu_clk_en);
        chk_bit("state hold", 1'h1, state_hold);
        chk_always_on();
    endtask

    // Raise a source, expect the wake three edges later with exp_dec
    task automatic wake_by(input logic nmi_v, input logic [18:0] src,
                           input logic [4:0] exp_dec);
        int n;
        @(posedge clk);
        nmi_pin <= nmi_v;
        ext <= src;
        n = 0;
        do begin
            @(posedge clk);
            @(negedge clk);
            n++;
        end while (o_wake !== 1'h1 && n < 8);
        chk_bit("wake at third edge", 1'h1, (n == 3) ? 1'h1 : 1'h0);
        chk_bit("halted", 1'h0, halted);
        chk_bit("cpu clk", 1'h1, cpu_clk_en);
        chk_vec("decision", exp_dec, {ack_nmi, ack_mask, branch, exec_next,
                                      hold_pending});
        @(posedge clk);
        nmi_pin <= 1'h0;
        ext <= 19'h00000;
        @(negedge clk);
        chk_idle();
        repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Masked pins and a repeated halt keep the CPU stopped and frozen
    task automatic t_masked_hold;
        logic [15:0] s0;
        @(posedge clk);
        mask <= 19'h7ffff;
        do_halt();
        s0 = steps;
        @(posedge clk);
        ext <= 19'h7ffff;
        halt_exec <= 1'h1;
        @(posedge clk);
        halt_exec <= 1'h0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk_bit("halted masked", 1'h1, halted);
        chk_bit("steps frozen", 1'h1, (steps === s0) ? 1'h1 : 1'h0);
        chk_always_on();
        @(posedge clk);
        ext <= 19'h00000;
        repeat (4) @(posedge clk);
        mask <= 19'h00000;
        wake_by(1'h1, 19'h00000, 5'h14);
    endtask

    // Every source wakes; under DI each external source resumes at the next instruction
    task automatic t_all_sources;
        ei <= 1'h0;
        for (int i = 0; i < 19; i++) begin
            do_halt();
            wake_by(1'h0, 19'h00001 << i, 5'h03);
        end
        do_halt();
        wake_by(1'h1, 19'h00000, 5'h14);
        ei <= 1'h1;
        do_halt();
        wake_by(1'h0, 19'h00010, 5'h0c);
    endtask

    // Halted in a level-3 routine: lower waits, higher and NMI are taken
    task automatic t_in_service;
        ei <= 1'h1;
        isr_active <= 1'h1;
        isr_prio <= 3'h3;
        do_halt();
        wake_by(1'h0, 19'h00020, 5'h03);
        do_halt();
        wake_by(1'h0, 19'h00008, 5'h03);
        do_halt();
        wake_by(1'h0, 19'h00002, 5'h0c);
        do_halt();
        wake_by(1'h1, 19'h00000, 5'h14);
        isr_active <= 1'h0;
        // Inside the NMI routine every source wakes but stays pending
        nmi_in_service <= 1'h1;
        do_halt();
        wake_by(1'h1, 19'h00000, 5'h03);
        do_halt();
        wake_by(1'h0, 19'h00002, 5'h03);
        nmi_in_service <= 1'h0;
    endtask

    // The reset pin ends the halt like any ordinary reset
    task automatic t_reset_wake;
        do_halt();
        @(posedge clk);
        rstn <= 1'h0;
        @(negedge clk);
        chk_idle();
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        chk_idle();
    endtask

    initial begin
        rstn = 1'h0;
        halt_exec = 1'h0;
        nmi_pin = 1'h0;
        ext = 19'h00000;
        mask = 19'h00000;
        ei = 1'h0;
        isr_active = 1'h0;
        isr_prio = 3'h0;
        nmi_in_service = 1'h0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk_idle();
        @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        chk_idle();
        t_masked_hold();
        t_all_sources();
        t_in_service();
        t_reset_wake();
        test_done();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule // cpu_halt_power_save_tb
